/* verification/dual_autoreload_pwm_timer_bench.sv */
`timescale 1ns/1ns
module dual_autoreload_pwm_timer_bench;
  logic        clk, rst, psel, penable, pwrite, pready, pslverr, irq, tick, brk, cmp, cap, ccap, pulse;
  logic [1:0]  b;
  logic [3:0]  lvl, pwm;
  logic [7:0]  paddr, value;
  logic [31:0] pwdata, prdata, seed, rnd, cfg;
  logic [63:0] note;
  logic [63:0] notes [$];
  logic [11:0] tbl [3];
  int          num_errors, samples_checked, i;
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  dual_autoreload_pwm_timer u_dut (.CLK_I(clk), .RST_I(rst), .PSEL_I(psel), .PENABLE_I(penable),
    .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
    .PSLVERR_O(pslverr), .COMPANION_PULSE_I(pulse), .COMPANION_CAPTURE_INPUT_I(ccap), .COMPANION_VALUE_I(value),
    .TIMER_CAPTURE_INPUT_I(cap), .BREAK_PIN_I(brk), .COMPARATOR_I(cmp), .PULSE_OUTPUTS_O(pwm), .IRQ_O(irq));
  pwm_far_side u_far (.clk_i(clk), .rst_i(rst), .lvl_i(lvl), .tick_i(tick), .brk_o(brk), .cmp_o(cmp),
    .cap_o(cap), .ccap_o(ccap), .pulse_o(pulse), .value_o(value));
  task automatic final_report;
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      chk({31'h0, pready}, 32'h1, "pready");
      final_report();
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = 32'hffffffff);
    notes.push_back({e, m});
    xfer(1'b0, a, 32'h0);
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask
  always @(posedge clk) begin
    if (psel && penable && !pwrite && pready === 1'b1 && notes.size() > 0) begin
      note = notes.pop_front();
      chk(prdata & note[31:0], note[63:32], $sformatf("read %h", paddr));
    end
    if (psel && penable && pready === 1'b1) begin
      chk({31'h0, pslverr}, {31'h0, paddr > 8'h40}, "slave error");
    end
  end
  initial begin
    idle(100000);
    chk(32'h0, 32'h1, "run finished");
    final_report();
  end
  initial begin
    seed = 32'h5675;
    {psel, penable, pwrite, tick, paddr, pwdata, lvl} = '0;
    tbl = '{12'h112, 12'h128, 12'h020};
    num_errors = 0;
    samples_checked = 0;
    rst = 1'b1;
    idle(10);
    rst <= 1'b0;
    rd(8'h00, 32'h0);
    rd(8'h40, 32'h0);
    rd(8'h44, 32'h0);
    for (i = 0; i < 6; i++) begin
      rnd = $random(seed) & 32'hfff;
      wr(8'h08 + 8'(4 * i), rnd);
      rd(8'h08 + 8'(4 * i), rnd);
    end
    $display("test registers done");
    wr(8'h00, 32'h11);
    wr(8'h08, 32'hff0);
    wr(8'h0c, 32'hff0);
    wr(8'h10, 32'hff8);
    wr(8'h18, 32'hff8);
    wr(8'h20, 32'h5);
    idle(4400);
    rd(8'h04, 32'h53);
    @(negedge clk);
    chk({31'h0, irq}, 32'h1, "irq");
    $display("test compare done");
    @(posedge clk);
    lvl <= 4'h2;
    idle(4);
    rd(8'h04, 32'h57);
    wr(8'h00, 32'h01);
    wr(8'h00, 32'h09);
    wr(8'h04, 32'h04);
    wr(8'h00, 32'h49);
    lvl <= 4'h0;
    idle(4);
    rd(8'h04, 32'h0, 32'h4);
    lvl <= 4'h1;
    idle(4);
    rd(8'h04, 32'h4, 32'h4);
    rd(8'h38, 32'h5a000, 32'hff000);
    $display("test capture done");
    wr(8'h00, 32'h0);
    wr(8'h24, 32'h0f);
    wr(8'h2c, 32'h1);
    lvl <= 4'h8;
    wr(8'h28, 32'ha4);
    idle(3);
    rd(8'h28, 32'ha4);
    for (i = 0; i < 4; i++) begin
      cfg = {24'h0, 4'ha, 1'b0, i[1], 1'b1, i[0]};
      b = {i[1] ^ i[0], ~(i[1] ^ i[0])};
      wr(8'h28, cfg & 32'hfd);
      lvl <= {~b, 2'h0};
      wr(8'h28, cfg);
      idle(3);
      rd(8'h28, cfg);
      lvl <= {b, 2'h0};
      idle(3);
      rd(8'h28, cfg | 32'h8);
      rd(8'h08, 32'h0);
      rd(8'h3c, 32'h0);
      @(negedge clk);
      chk({28'h0, pwm}, 32'ha, "pattern");
      @(posedge clk);
      lvl <= {~b, 2'h0};
      idle(3);
      wr(8'h28, cfg);
      idle(3);
      rd(8'h28, cfg);
      @(negedge clk);
      chk({28'h0, pwm}, 32'h0, "timer output");
    end
    wr(8'h28, 32'haf);
    for (i = 0; i < 3; i++) begin
      wr(8'h00, {31'h0, tbl[i][8]});
      wr(8'h2c, {30'h0, tbl[i][5:4]});
      idle(3);
      @(negedge clk);
      chk({28'h0, pwm}, {28'h0, tbl[i][3:0]}, "break group");
    end
    $display("test break done");
    wr(8'h00, 32'h02);
    wr(8'h2c, 32'h1);
    idle(3);
    wr(8'h28, 32'ha7);
    idle(3);
    rd(8'h3c, 32'h0);
    tick <= 1'b1;
    idle(6);
    tick <= 1'b0;
    idle(3);
    rd(8'h3c, 32'h3);
    $display("test clock done");
    final_report();
  end
endmodule // dual_autoreload_pwm_timer_bench

/* verification/pwm_far_side.sv */
`timescale 1ns/1ns
module pwm_far_side (
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // levels and tick request from the bench
  input  wire logic [3:0] lvl_i,
  input  wire logic       tick_i,
  // pins toward the timer
  output logic            brk_o,
  output logic            cmp_o,
  output logic            cap_o,
  output logic            ccap_o,
  output logic            pulse_o,
  output logic [7:0]      value_o
);
  always_ff @(posedge clk_i) begin
    {brk_o, cmp_o, cap_o, ccap_o} <= lvl_i;
    pulse_o <= ~rst_i & tick_i & ~pulse_o;
    if (rst_i) value_o <= 8'h5a;
    else if (pulse_o) value_o <= value_o + 8'h01;
  end
endmodule // pwm_far_side

/* verification/pwm_timer_checker.sv */
`timescale 1ns/1ns
module pwm_timer_checker (
  // clock, reset, apb
  input wire logic        CLK_I,
  input wire logic        RST_I,
  input wire logic        PSEL_I,
  input wire logic        PENABLE_I,
  input wire logic        PWRITE_I,
  input wire logic [7:0]  PADDR_I,
  input wire logic [31:0] PWDATA_I,
  input wire logic [31:0] PRDATA_O,
  input wire logic        PSLVERR_O,
  // pins
  input wire logic        BREAK_PIN_I,
  input wire logic [3:0]  PULSE_OUTPUTS_O,
  input wire logic        IRQ_O
);
  default clocking @(posedge CLK_I); endclocking
  default disable iff (RST_I);
  logic       acc, rd, bad;
  logic [7:0] ctrl_reg, oe_reg, brk_reg;
  logic [1:0] ben_reg;
  assign acc = PSEL_I & PENABLE_I;
  assign rd  = acc & ~PWRITE_I;
  assign bad = (PADDR_I[1:0] != 2'h0) | (PADDR_I > 8'h40);
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      {ctrl_reg, oe_reg, brk_reg, ben_reg} <= 26'h0;
    end else if (acc & PWRITE_I) begin
      if (PADDR_I == 8'h00) ctrl_reg <= PWDATA_I[7:0];
      if (PADDR_I == 8'h24) oe_reg <= PWDATA_I[7:0];
      if (PADDR_I == 8'h28) brk_reg <= PWDATA_I[7:0];
      if (PADDR_I == 8'h2c) ben_reg <= PWDATA_I[1:0];
    end
  end
  sequence s_pin_break;
    brk_reg[1] & ~brk_reg[0] & brk_reg[2] & ben_reg[0] & ~ctrl_reg[0] & BREAK_PIN_I;
  endsequence
  a_brk_pattern: assert property (s_pin_break [*3] |=> PULSE_OUTPUTS_O == (brk_reg[7:4] & oe_reg[3:0]))
    else $error("break pattern missing");
  a_brk_reload: assert property (s_pin_break [*4] ##0 (rd && PADDR_I == 8'h08) |-> PRDATA_O == 32'h0)
    else $error("reload kept in break");
  a_oe_low: assert property ((~oe_reg[3:0] & ~$past(oe_reg[3:0]) & PULSE_OUTPUTS_O) == 4'h0)
    else $error("disabled output high");
  a_irq_masked: assert property (ctrl_reg[7:4] == 4'h0 |-> !IRQ_O)
    else $error("irq while masked");
  a_cnt2_idle: assert property (rd && PADDR_I == 8'h40 && !(ctrl_reg[0] | $past(ctrl_reg[0]) |
    $past(ctrl_reg[0], 2) | $past(ctrl_reg[0], 3)) |-> PRDATA_O == 32'h0) else $error("counter two runs");
  a_rd_width: assert property (rd |-> PRDATA_O[31:20] == 12'h000)
    else $error("read data too wide");
  a_err_flag: assert property (PSLVERR_O == (acc & bad))
    else $error("slave error wrong");
  a_bad_read: assert property (rd && bad |-> PRDATA_O == 32'h0)
    else $error("unmapped read not zero");
  c_pin_break: cover property (s_pin_break [*3]);
  c_bad: cover property (acc && bad);
  c_irq: cover property (IRQ_O);
endmodule // pwm_timer_checker
bind dual_autoreload_pwm_timer pwm_timer_checker u_checker (.CLK_I, .RST_I, .PSEL_I, .PENABLE_I, .PWRITE_I,
  .PADDR_I, .PWDATA_I, .PRDATA_O, .PSLVERR_O, .BREAK_PIN_I, .PULSE_OUTPUTS_O, .IRQ_O);

/* verilog/dual_autoreload_pwm_timer.sv */
// Implementation choices: register access over APB and the address map.
`timescale 1ns/1ns
`include "pwm_timer_consts.svh"
// Summary of operation
// - one or two 12-bit upcounters, mode bit
// - break trigger from pin or comparator
// - break trigger ignored until function enabled
// - active level sets break flag, activates break
// - software setting flag also activates break
// - per-counter break enables govern output groups
// - enabled outputs forced to pattern after inverter
// - break clears counters whose enable set
// - break resets reload, duty; counters stop
// - clearing flag returns outputs to timer
// - counter equals duty sets flag, interrupt
// - channel-to-counter pairing depends on mode
// - zero duty value never matches
// - preload duty copied at overflow if enabled
// - both capture edges latch counter, flag
// - clock select 01 uses companion pulse
// - capture source select picks companion pin
// - companion and own capture form 20 bits
module dual_autoreload_pwm_timer (
  // clock and reset
  input  wire logic        CLK_I,
  input  wire logic        RST_I,
  // apb slave
  input  wire logic        PSEL_I,
  input  wire logic        PENABLE_I,
  input  wire logic        PWRITE_I,
  input  wire logic [7:0]  PADDR_I,
  input  wire logic [31:0] PWDATA_I,
  output logic      [31:0] PRDATA_O,
  output logic             PREADY_O,
  output logic             PSLVERR_O,
  // companion low-speed timer
  input  wire logic        COMPANION_PULSE_I,
  input  wire logic        COMPANION_CAPTURE_INPUT_I,
  input  wire logic [7:0]  COMPANION_VALUE_I,
  // capture and break inputs
  input  wire logic        TIMER_CAPTURE_INPUT_I,
  input  wire logic        BREAK_PIN_I,
  input  wire logic        COMPARATOR_I,
  // outputs
  output logic      [3:0]  PULSE_OUTPUTS_O,
  output logic             IRQ_O
);

  function automatic logic duty_hit(input logic [11:0] cnt, input logic [11:0] duty);
    duty_hit = (duty != `RST_DUTY) && (cnt == duty);
  endfunction

  function automatic logic [11:0] take12(input logic [31:0] d);
    take12 = d[11:0];
  endfunction

  pwm_timer_pkg::timer_ctrl_s ctrl_reg;
  pwm_timer_pkg::break_ctrl_s brk_reg;
  pwm_timer_pkg::timer_mode_e mode;
  logic        ba_reg;
  logic [1:0]  bren_reg;
  logic [1:0]  ovf_flag_reg;
  logic        cap_flag_reg;
  logic [3:0]  cmp_flag_reg;
  logic [11:0] reload_reg [2];
  logic [11:0] cnt_reg    [2];
  logic [11:0] pre_duty_reg [4];
  logic [11:0] act_duty_reg [4];
  logic [3:0]  tran_reg;
  logic [3:0]  oe_reg;
  logic [3:0]  pol_reg;
  logic [11:0] cap_reg;
  logic [7:0]  comp_cap_reg;
  logic        cap_prev_reg;
  logic [31:0] prdata_reg;
  logic        pslverr_reg;
  logic [3:0]  pulse_reg;
  logic [31:0] rd_data;

  // bus decode
  wire         wr_en   = PSEL_I & PENABLE_I & PWRITE_I;
  wire         setup   = PSEL_I & ~PENABLE_I;
  wire [7:0]   addr    = PADDR_I;
  wire         wr_ctrl = wr_en && addr == `OFS_TIMER_CTRL;
  wire         wr_flg  = wr_en && addr == `OFS_FLAGS;
  wire         wr_rl1  = wr_en && addr == `OFS_RELOAD1;
  wire         wr_rl2  = wr_en && addr == `OFS_RELOAD2;
  wire         wr_tran = wr_en && addr == `OFS_TRANSFER;
  wire         wr_out  = wr_en && addr == `OFS_OUT_CTRL;
  wire         wr_brk  = wr_en && addr == `OFS_BREAK_CTRL;
  wire         wr_bren = wr_en && addr == `OFS_BREAK_EN;
  wire [3:0]   wr_duty;
  assign wr_duty[0] = wr_en && addr == `OFS_DUTY0;
  assign wr_duty[1] = wr_en && addr == `OFS_DUTY1;
  assign wr_duty[2] = wr_en && addr == `OFS_DUTY2;
  assign wr_duty[3] = wr_en && addr == `OFS_DUTY3;

  assign mode = ctrl_reg.second_counter_enable ? pwm_timer_pkg::MODE_DUAL
                                                : pwm_timer_pkg::MODE_SINGLE;
  wire dual = (mode == pwm_timer_pkg::MODE_DUAL);

  wire tick = (ctrl_reg.counter_clock_select == `CLK_SEL_COMPANION) ? COMPANION_PULSE_I : 1'b1;

  wire brk_src = brk_reg.break_source_select ? COMPARATOR_I : BREAK_PIN_I;
  wire brk_trig = brk_reg.break_function_enable &
                  (brk_reg.break_level_select ? brk_src : ~brk_src);

  wire brk1    = ba_reg & bren_reg[0];
  wire brk2    = ba_reg & bren_reg[1];
  wire brk_any = brk1 | brk2;
  wire [3:0] ch_brk = dual ? {brk2, brk2, brk1, brk1} : {4{brk1}};

  wire [1:0] run = {dual & ~brk_any, ~brk_any};
  wire [1:0] ovf;
  assign ovf[0] = run[0] & tick & (cnt_reg[0] == `CNT_MAX);
  assign ovf[1] = run[1] & tick & (cnt_reg[1] == `CNT_MAX);

  wire [11:0] ch_cnt [4];
  assign ch_cnt[0] = cnt_reg[0];
  assign ch_cnt[1] = cnt_reg[0];
  assign ch_cnt[2] = dual ? cnt_reg[1] : cnt_reg[0];
  assign ch_cnt[3] = dual ? cnt_reg[1] : cnt_reg[0];
  wire [3:0] ch_ovf = dual ? {ovf[1], ovf[1], ovf[0], ovf[0]} : {4{ovf[0]}};

  wire [3:0] cmp_hit;
  assign cmp_hit[0] = duty_hit(ch_cnt[0], act_duty_reg[0]);
  assign cmp_hit[1] = duty_hit(ch_cnt[1], act_duty_reg[1]);
  assign cmp_hit[2] = duty_hit(ch_cnt[2], act_duty_reg[2]);
  assign cmp_hit[3] = duty_hit(ch_cnt[3], act_duty_reg[3]);

  wire cap_in  = ctrl_reg.capture_source_select ? COMPANION_CAPTURE_INPUT_I
                                                : TIMER_CAPTURE_INPUT_I;
  wire cap_evt = cap_in ^ cap_prev_reg;

  // pwm levels before break
  wire [3:0] raw_pwm;
  assign raw_pwm[0] = ch_cnt[0] < act_duty_reg[0];
  assign raw_pwm[1] = ch_cnt[1] < act_duty_reg[1];
  assign raw_pwm[2] = ch_cnt[2] < act_duty_reg[2];
  assign raw_pwm[3] = ch_cnt[3] < act_duty_reg[3];
  wire [3:0] inv_pwm = raw_pwm ^ pol_reg;
  wire [3:0] pulse_next = oe_reg & ((ch_brk & brk_reg.pattern) | (~ch_brk & inv_pwm));

  // control registers
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      ctrl_reg <= '0;
      brk_reg  <= '0;
      bren_reg <= 2'h0;
      tran_reg <= 4'h0;
      oe_reg   <= 4'h0;
      pol_reg  <= 4'h0;
    end else begin
      if (wr_ctrl) ctrl_reg <= PWDATA_I[7:0];
      if (wr_brk) brk_reg <= {PWDATA_I[7:4], PWDATA_I[2:0]};
      if (wr_bren) bren_reg <= PWDATA_I[1:0];
      if (wr_tran) tran_reg <= PWDATA_I[3:0];
      if (wr_out) begin
        oe_reg  <= PWDATA_I[3:0];
        pol_reg <= PWDATA_I[7:4];
      end
    end
  end

  // break active flag, set wins over clear
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      ba_reg <= 1'b0;
    end else if (brk_trig) begin
      ba_reg <= 1'b1;
    end else if (wr_brk) begin
      ba_reg <= PWDATA_I[3];
    end
  end

  // reload values
  always_ff @(posedge CLK_I) begin
    if (RST_I || brk_any) begin
      reload_reg[0] <= `RST_RELOAD;
      reload_reg[1] <= `RST_RELOAD;
    end else begin
      if (wr_rl1) reload_reg[0] <= take12(PWDATA_I);
      if (wr_rl2) reload_reg[1] <= take12(PWDATA_I);
    end
  end

  // counters
  always_ff @(posedge CLK_I) begin
    for (int k = 0; k < 2; k++) begin
      if (RST_I || (k == 1 && !dual)) begin
        cnt_reg[k] <= `RST_COUNT;
      end else if (k == 0 ? brk1 : brk2) begin
        cnt_reg[k] <= `RST_COUNT;
      end else if (run[k] && tick) begin
        cnt_reg[k] <= ovf[k] ? reload_reg[k] : cnt_reg[k] + 12'h001;
      end
    end
  end

  // duty registers
  always_ff @(posedge CLK_I) begin
    for (int c = 0; c < 4; c++) begin
      if (RST_I || brk_any) begin
        pre_duty_reg[c] <= `RST_DUTY;
        act_duty_reg[c] <= `RST_DUTY;
      end else begin
        if (wr_duty[c]) pre_duty_reg[c] <= take12(PWDATA_I);
        if (ch_ovf[c] && tran_reg[c]) act_duty_reg[c] <= pre_duty_reg[c];
      end
    end
  end

  // sticky flags, write one to clear, set wins
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      ovf_flag_reg <= 2'h0;
      cap_flag_reg <= 1'b0;
      cmp_flag_reg <= 4'h0;
    end else begin
      ovf_flag_reg <= ovf | (ovf_flag_reg & ~({2{wr_flg}} & PWDATA_I[`FLG_OVF2:`FLG_OVF1]));
      cap_flag_reg <= cap_evt | (cap_flag_reg & ~(wr_flg & PWDATA_I[`FLG_CAPTURE]));
      cmp_flag_reg <= cmp_hit | (cmp_flag_reg & ~({4{wr_flg}} & PWDATA_I[`FLG_CMP_LSB+:4]));
    end
  end

  // capture latch
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      // follow the pin so reset leaves no false edge
      cap_prev_reg <= cap_in;
      cap_reg      <= `RST_COUNT;
      comp_cap_reg <= 8'h00;
    end else begin
      cap_prev_reg <= cap_in;
      if (cap_evt) begin
        cap_reg      <= cnt_reg[0];
        comp_cap_reg <= COMPANION_VALUE_I;
      end
    end
  end

  // output and bus registers
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      pulse_reg   <= 4'h0;
      prdata_reg  <= 32'h0;
      pslverr_reg <= 1'b0;
    end else begin
      pulse_reg <= pulse_next;
      if (setup) begin
        prdata_reg  <= PWRITE_I ? 32'h0 : rd_data;
        pslverr_reg <= (addr[1:0] != 2'h0) || (addr > `OFS_COUNTER2);
      end
    end
  end

  // read selection
  always_comb begin
    rd_data = 32'h0;
    case (addr)
      `OFS_TIMER_CTRL:   rd_data = {24'h0, ctrl_reg};
      `OFS_FLAGS:        rd_data = {24'h0, cmp_flag_reg, 1'b0, cap_flag_reg, ovf_flag_reg};
      `OFS_RELOAD1:      rd_data = {20'h0, reload_reg[0]};
      `OFS_RELOAD2:      rd_data = {20'h0, reload_reg[1]};
      `OFS_DUTY0:        rd_data = {20'h0, pre_duty_reg[0]};
      `OFS_DUTY1:        rd_data = {20'h0, pre_duty_reg[1]};
      `OFS_DUTY2:        rd_data = {20'h0, pre_duty_reg[2]};
      `OFS_DUTY3:        rd_data = {20'h0, pre_duty_reg[3]};
      `OFS_TRANSFER:     rd_data = {28'h0, tran_reg};
      `OFS_OUT_CTRL:     rd_data = {24'h0, pol_reg, oe_reg};
      `OFS_BREAK_CTRL:   rd_data = {24'h0, brk_reg.pattern, ba_reg, brk_reg.break_level_select,
                                    brk_reg.break_function_enable, brk_reg.break_source_select};
      `OFS_BREAK_EN:     rd_data = {30'h0, bren_reg};
      `OFS_CAPTURE:      rd_data = {20'h0, cap_reg};
      `OFS_COMP_CAPTURE: rd_data = {24'h0, comp_cap_reg};
      `OFS_LONG_CAPTURE: rd_data = {12'h0, comp_cap_reg, cap_reg};
      `OFS_COUNTER1:     rd_data = {20'h0, cnt_reg[0]};
      `OFS_COUNTER2:     rd_data = {20'h0, cnt_reg[1]};
      default:           rd_data = 32'h0;
    endcase
  end

  assign PRDATA_O        = prdata_reg;
  assign PREADY_O        = 1'b1;
  assign PSLVERR_O       = pslverr_reg & PSEL_I & PENABLE_I;
  assign PULSE_OUTPUTS_O = pulse_reg;
  assign IRQ_O = (ctrl_reg.cmp_irq_en & |cmp_flag_reg)
               | (ctrl_reg.cap_irq_en & cap_flag_reg)
               | (ctrl_reg.ovf1_irq_en & ovf_flag_reg[0])
               | (ctrl_reg.ovf2_irq_en & ovf_flag_reg[1]);

endmodule // dual_autoreload_pwm_timer

/* verilog/pwm_timer_consts.svh */
`ifndef PWM_TIMER_CONSTS_SVH
`define PWM_TIMER_CONSTS_SVH
// register byte offsets
`define OFS_TIMER_CTRL    8'h00
`define OFS_FLAGS         8'h04
`define OFS_RELOAD1       8'h08
`define OFS_RELOAD2       8'h0c
`define OFS_DUTY0         8'h10
`define OFS_DUTY1         8'h14
`define OFS_DUTY2         8'h18
`define OFS_DUTY3         8'h1c
`define OFS_TRANSFER      8'h20
`define OFS_OUT_CTRL      8'h24
`define OFS_BREAK_CTRL    8'h28
`define OFS_BREAK_EN      8'h2c
`define OFS_CAPTURE       8'h30
`define OFS_COMP_CAPTURE  8'h34
`define OFS_LONG_CAPTURE  8'h38
`define OFS_COUNTER1      8'h3c
`define OFS_COUNTER2      8'h40
// flag register bit positions
`define FLG_OVF1          0
`define FLG_OVF2          1
`define FLG_CAPTURE       2
`define FLG_CMP_LSB       4
// clock select code for companion pulse
`define CLK_SEL_COMPANION 2'h1
// reset values and counter maximum
`define RST_COUNT         12'h000
`define RST_RELOAD        12'h000
`define RST_DUTY          12'h000
`define CNT_MAX           12'hfff
`endif

/* verilog/pwm_timer_pkg.sv */
package pwm_timer_pkg;
  // timer control register
  typedef struct packed {
    logic       cmp_irq_en;
    logic       cap_irq_en;
    logic       ovf2_irq_en;
    logic       ovf1_irq_en;
    logic       capture_source_select;
    logic [1:0] counter_clock_select;
    logic       second_counter_enable;
  } timer_ctrl_s;
  // break control register (break active flag kept apart)
  typedef struct packed {
    logic [3:0] pattern;
    logic       break_level_select;
    logic       break_function_enable;
    logic       break_source_select;
  } break_ctrl_s;
  typedef enum logic [1:0] {
    MODE_SINGLE = 2'b01,
    MODE_DUAL   = 2'b10
  } timer_mode_e;
endpackage
